// file: src/xms_pkg.sv
package xms_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MDC_MAX_HZ      = 2_500_000;
  // host divider: half period in sys cycles, rounded up so mdc never exceeds the limit
  localparam int unsigned MDC_HALF_CYC    = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int unsigned PREAMBLE_LEN    = 32;
  localparam int unsigned DATA_LEN        = 16;
  localparam int unsigned FLD_LEN         = 5;
  localparam logic [1:0]  START_CODE      = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  MODE_SEL_ACTIVE = 2'h1;
  localparam int unsigned PHY_EXT_BIT     = 4;
  localparam int unsigned HALF_SEL_BIT    = 0;
  localparam int unsigned SYS_ADDR_W      = 10;
  localparam int unsigned FRAME_HDR_LEN   = 14;
  localparam int unsigned FRAME_BODY_LEN  = 32;
  typedef logic [SYS_ADDR_W-1:0] xms_addr_t;
endpackage

// file: src/xms_link_if.sv
`timescale 1ns/10ps
interface xms_link_if;
  logic mdc;
  logic mdio_dev_o;
  logic mdio_dev_oe_n;
  logic mdio_host_o;
  logic mdio_host_oe_n;
  // pull-up: line high unless a party drives it
  logic mdio;
  assign mdio = !mdio_dev_oe_n ? mdio_dev_o : (!mdio_host_oe_n ? mdio_host_o : 1'b1);
  modport dev  (input mdc, input mdio, output mdio_dev_o, output mdio_dev_oe_n);
  modport host (output mdc, input mdio, output mdio_host_o, output mdio_host_oe_n);
endinterface

// file: src/xms_dev.sv
`timescale 1ns/10ps
// What this block does
// - answer only phy addresses 16 to 31
// - active only when mode straps equal 01
// - phy bits 3:0 and reg field form address
// - reg bit 0 picks upper or lower half
// - two frames, opposite halves, form one access
// - host sends pair atomically, nothing between
// - host keeps other address bits identical
// - sample and drive data on rising mdc
// - release mdio except when sending read data
// - msb first, bytes little endian across halves
// - read turnaround: release, zero, then msb
// - write turnaround driven one then zero
// - idle line released, pulled high
// - host mdc at most 2.5 MHz
// - sixteen data bits, five-bit address fields
// - only even system addresses reachable, address bit 0 held zero
// - preamble ones, start 01, opcode
// - repeated read half restarts pairing
// - repeated write half discarded
// - read data may be invalid during reset
module xms_dev
  import xms_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  xms_link_if.dev                link,
  input  wire logic [1:0]        mode_strap,
  output logic                   reg_wr_r,
  output logic                   reg_rd_r,
  output xms_pkg::xms_addr_t     reg_addr_r,
  output logic [31:0]            reg_wdata_r,
  input  wire logic [31:0]       reg_rdata
);
  import xms_pkg::*;

  typedef enum {XMS_PRE, XMS_HDR, XMS_TA, XMS_RDATA, XMS_WDATA} xms_state_t;

  xms_state_t  state_r;
  logic [2:0]  mdc_sync_r;
  logic [1:0]  mdio_sync_r;
  logic [1:0]  strap_sync_r;
  logic [5:0]  cnt_r;
  logic [13:0] hdr_r;
  logic [15:0] sh_r;
  logic        mine_r;
  logic        pend_r;
  logic        pend_half_r;
  logic        pend_wr_r;
  logic [15:0] stage_r;
  logic [31:0] latch_r;
  logic [1:0]  strap_hi_r;
  logic [1:0]  strap_now;
  logic [15:0] latch_nxt_hi;
  logic [15:0] latch_nxt_lo;
  logic        rd_second;

  logic mdc_rise;
  logic din;
  logic is_read;
  logic hit;
  logic half;
  always_comb begin
    mdc_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
    din      = mdio_sync_r[1];
    is_read  = hdr_r[11:10] == OP_READ;
    half     = hdr_r[HALF_SEL_BIT];
    strap_now = {strap_hi_r[1], strap_sync_r[1]};
    hit      = hdr_r[13:12] == START_CODE && hdr_r[5 + PHY_EXT_BIT]
               && strap_now == MODE_SEL_ACTIVE
               && (is_read || hdr_r[11:10] == OP_WRITE);
  end

  // pins and straps come from outside the domain; first stage read by second only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mdc_sync_r   <= 3'h0;
      mdio_sync_r  <= 2'h3;
      strap_sync_r <= 2'h0;
    end else begin
      mdc_sync_r   <= {mdc_sync_r[1:0], link.mdc};
      mdio_sync_r  <= {mdio_sync_r[0], link.mdio};
      strap_sync_r <= {strap_sync_r[0], mode_strap[0]};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strap_hi_r <= 2'h0;
    end else begin
      strap_hi_r <= {strap_hi_r[0], mode_strap[1]};
    end
  end

  // frame receiver, all sampling on rising mdc
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= XMS_PRE;
      cnt_r   <= 6'h00;
      hdr_r   <= 14'h0000;
      sh_r    <= 16'h0000;
      mine_r  <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        XMS_PRE: begin
          if (din) begin
            if (cnt_r != 6'(PREAMBLE_LEN)) begin
              cnt_r <= cnt_r + 6'h01;
            end
          end else if (cnt_r == 6'(PREAMBLE_LEN)) begin
            hdr_r   <= 14'h0000;
            cnt_r   <= 6'h01;
            state_r <= XMS_HDR;
          end else begin
            cnt_r <= 6'h00;
          end
        end
        XMS_HDR: begin
          hdr_r <= {hdr_r[12:0], din};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(FRAME_HDR_LEN - 1)) begin
            cnt_r   <= 6'h00;
            state_r <= XMS_TA;
          end
        end
        XMS_TA: begin
          if (cnt_r == 6'h00) begin
            mine_r <= hit && strap_now == MODE_SEL_ACTIVE;
            cnt_r  <= 6'h01;
          end else begin
            cnt_r   <= 6'h00;
            sh_r    <= half ? latch_nxt_hi : latch_nxt_lo;
            state_r <= is_read ? XMS_RDATA : XMS_WDATA;
          end
        end
        XMS_RDATA: begin
          sh_r  <= {sh_r[14:0], 1'b0};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(DATA_LEN - 1)) begin
            cnt_r   <= 6'h00;
            state_r <= XMS_PRE;
          end
        end
        XMS_WDATA: begin
          sh_r  <= {sh_r[14:0], din};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(DATA_LEN - 1)) begin
            cnt_r   <= 6'h00;
            state_r <= XMS_PRE;
          end
        end
        default: state_r <= XMS_PRE;
      endcase
    end
  end

  // read value: latched at the turnaround of a first half and held for the second,
  // so a register that moves between the halves still reads as one consistent word
  always_comb begin
    rd_second    = pend_r && !pend_wr_r && pend_half_r != half;
    latch_nxt_hi = latch_r[31:16];
    latch_nxt_lo = latch_r[15:0];
  end

  wire logic       frame_hit  = state_r == XMS_TA && cnt_r == 6'h00 && mdc_rise
                                && hit && strap_now == MODE_SEL_ACTIVE;
  wire logic       wr_done    = state_r == XMS_WDATA && mdc_rise && mine_r
                                && cnt_r == 6'(DATA_LEN - 1);
  wire logic [15:0] wr_word   = {sh_r[14:0], din};

  // pairing tracker
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_r      <= 1'b0;
      pend_half_r <= 1'b0;
      pend_wr_r   <= 1'b0;
      stage_r     <= 16'h0000;
      latch_r     <= 32'h0000_0000;
      reg_wr_r    <= 1'b0;
      reg_rd_r    <= 1'b0;
      reg_addr_r  <= '0;
      reg_wdata_r <= 32'h0000_0000;
    end else begin
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      if (strap_now != MODE_SEL_ACTIVE) begin
        pend_r <= 1'b0;
      end
      if (frame_hit) begin
        reg_addr_r <= {hdr_r[8:5], hdr_r[4:0], 1'b0};
        if (is_read) begin
          if (!rd_second) begin
            latch_r     <= reg_rdata;
            pend_r      <= 1'b1;
            pend_half_r <= half;
            pend_wr_r   <= 1'b0;
          end else begin
            pend_r   <= 1'b0;
            reg_rd_r <= 1'b1;
          end
        end
      end
      if (wr_done) begin
        if (pend_r && pend_wr_r && pend_half_r != half) begin
          reg_wdata_r <= half ? {wr_word, stage_r} : {stage_r, wr_word};
          reg_wr_r    <= 1'b1;
          pend_r      <= 1'b0;
        end else if (pend_r && pend_wr_r) begin
          pend_r <= 1'b0;
        end else begin
          stage_r     <= wr_word;
          pend_r      <= 1'b1;
          pend_half_r <= half;
          pend_wr_r   <= 1'b1;
        end
      end
    end
  end

  // output driver, changes on rising mdc
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      link.mdio_dev_o    <= 1'b1;
      link.mdio_dev_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      if (state_r == XMS_TA && cnt_r == 6'h00 && is_read && hit && strap_now == MODE_SEL_ACTIVE) begin
        link.mdio_dev_o    <= 1'b0;
        link.mdio_dev_oe_n <= 1'b0;
      end else if (state_r == XMS_TA && cnt_r != 6'h00 && is_read && mine_r) begin
        link.mdio_dev_o    <= half ? latch_nxt_hi[15] : latch_nxt_lo[15];
        link.mdio_dev_oe_n <= 1'b0;
      end else if (state_r == XMS_RDATA && cnt_r != 6'(DATA_LEN - 1) && mine_r) begin
        link.mdio_dev_o    <= sh_r[14];
        link.mdio_dev_oe_n <= 1'b0;
      end else begin
        link.mdio_dev_o    <= 1'b1;
        link.mdio_dev_oe_n <= 1'b1;
      end
    end
  end
endmodule

// file: src/xms_host.sv
`timescale 1ns/10ps
module xms_host
  import xms_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  xms_link_if.host               link,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire xms_pkg::xms_addr_t cmd_addr,
  input  wire logic [31:0]       cmd_wdata,
  output logic                   cmd_ready_r,
  output logic                   rsp_valid_r,
  output logic [31:0]            rsp_rdata_r
);
  import xms_pkg::*;

  typedef enum {XMH_IDLE, XMH_FRAME} xms_hstate_t;

  xms_hstate_t state_r;
  logic [7:0]  div_r;
  logic        half_r;
  logic [6:0]  bit_r;
  logic [63:0] frame_r;
  logic        wr_r;
  logic        second_r;
  xms_addr_t   addr_r;
  logic [31:0] wdata_r;
  logic [15:0] rd_r;
  logic [15:0] first_rd_r;
  logic [1:0]  mdio_sync_r;

  localparam int unsigned FRAME_BITS = PREAMBLE_LEN + FRAME_BODY_LEN;
  wire logic tick = div_r == 8'(MDC_HALF_CYC - 1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mdio_sync_r <= 2'h3;
    end else begin
      mdio_sync_r <= {mdio_sync_r[0], link.mdio};
    end
  end

  // frame word: preamble, start, opcode, phy, reg, turnaround, data; second frame takes the other half
  function automatic logic [63:0] build(input logic w, input xms_addr_t a, input logic h, input logic [31:0] d);
    logic [15:0] dw;
    dw = h ? d[31:16] : d[15:0];
    build = {32'hFFFF_FFFF, START_CODE, w ? OP_WRITE : OP_READ,
             1'b1, a[9:6], a[5:2], h,
             w ? 2'h2 : 2'h3, w ? dw : 16'hFFFF};
  endfunction

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r        <= XMH_IDLE;
      div_r          <= 8'h00;
      half_r         <= 1'b0;
      bit_r          <= 7'h00;
      frame_r        <= 64'h0;
      wr_r           <= 1'b0;
      second_r       <= 1'b0;
      addr_r         <= '0;
      wdata_r        <= 32'h0000_0000;
      rd_r           <= 16'h0000;
      first_rd_r     <= 16'h0000;
      cmd_ready_r    <= 1'b0;
      rsp_valid_r    <= 1'b0;
      rsp_rdata_r    <= 32'h0000_0000;
      link.mdc       <= 1'b0;
      link.mdio_host_o    <= 1'b1;
      link.mdio_host_oe_n <= 1'b1;
    end else begin
      rsp_valid_r <= 1'b0;
      cmd_ready_r <= state_r == XMH_IDLE;
      case (state_r)
        XMH_IDLE: begin
          link.mdio_host_oe_n <= 1'b1;
          if (cmd_valid && cmd_ready_r) begin
            cmd_ready_r <= 1'b0;
            wr_r     <= cmd_write;
            addr_r   <= cmd_addr;
            wdata_r  <= cmd_wdata;
            second_r <= 1'b0;
            frame_r  <= build(cmd_write, cmd_addr, 1'b0, cmd_wdata);
            bit_r    <= 7'h00;
            div_r    <= 8'h00;
            half_r   <= 1'b0;
            state_r  <= XMH_FRAME;
          end
        end
        XMH_FRAME: begin
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (tick) begin
            half_r   <= ~half_r;
            link.mdc <= half_r;
            if (!half_r) begin
              if (bit_r == 7'(FRAME_BITS)) begin
                // one more low half so mdc rests at its idle level between commands
                state_r             <= XMH_IDLE;
                link.mdio_host_oe_n <= 1'b1;
                rsp_valid_r         <= !wr_r;
              end else begin
                // data set up half a period before the rising edge
                link.mdio_host_o    <= frame_r[63];
                link.mdio_host_oe_n <= !(wr_r || bit_r < 7'(PREAMBLE_LEN + FRAME_HDR_LEN));
              end
            end else begin
              // rising edge: read data was launched by the far end on the previous rise
              frame_r <= {frame_r[62:0], 1'b1};
              if (bit_r >= 7'(FRAME_BITS - DATA_LEN)) begin
                rd_r <= {rd_r[14:0], mdio_sync_r[1]};
              end
              bit_r <= bit_r + 7'h01;
              if (bit_r == 7'(FRAME_BITS - 1)) begin
                bit_r <= 7'h00;
                if (!second_r) begin
                  second_r   <= 1'b1;
                  first_rd_r <= {rd_r[14:0], mdio_sync_r[1]};
                  frame_r    <= build(wr_r, addr_r, 1'b1, wdata_r);
                end else begin
                  bit_r <= 7'(FRAME_BITS);
                  if (!wr_r) begin
                    rsp_rdata_r <= {rd_r[14:0], mdio_sync_r[1], first_rd_r};
                  end
                end
              end
            end
          end
        end
        default: state_r <= XMH_IDLE;
      endcase
    end
  end
endmodule

// file: testbench/xms_link_asserts.sv
`timescale 1ns/10ps
module xms_link_asserts
  import xms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_dev_o,
  input wire logic mdio_dev_oe_n,
  input wire logic mdio_host_o,
  input wire logic mdio_host_oe_n,
  input wire logic mdio
);
  logic       mdc_q_r;
  logic [7:0] since_rise_r;
  logic [7:0] stable_r;
  logic [5:0] drv_rises_r;
  logic       mdc_rise;
  assign mdc_rise = mdc && !mdc_q_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      mdc_q_r <= 1'h0;
    else
      mdc_q_r <= mdc;
  end
  // saturating counters start full so the first edge after reset never looks early
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      since_rise_r <= 8'hFF;
    else if (mdc_rise)
      since_rise_r <= 8'h00;
    else if (since_rise_r != 8'hFF)
      since_rise_r <= since_rise_r + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      stable_r <= 8'hFF;
    else if (mdc != mdc_q_r)
      stable_r <= 8'h00;
    else if (stable_r != 8'hFF)
      stable_r <= stable_r + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      drv_rises_r <= 6'h00;
    else if (mdio_dev_oe_n)
      drv_rises_r <= 6'h00;
    else if (mdc_rise)
      drv_rises_r <= drv_rises_r + 6'h01;
  end
  property p_no_clash;
    !(!mdio_dev_oe_n && !mdio_host_oe_n);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("mdio driven by both ends");
  property p_pull;
    mdio_dev_oe_n && mdio_host_oe_n |-> mdio;
  endproperty
  a_pull: assert property (p_pull) else $error("released mdio not high");
  property p_dev_edge;
    !mdio_dev_oe_n && $changed(mdio_dev_o) |-> since_rise_r <= 8'h06;
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("read data changed away from mdc rise");
  property p_oe_edge;
    $changed(mdio_dev_oe_n) |-> since_rise_r <= 8'h06;
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("device enable moved away from mdc rise");
  property p_ta_zero;
    !mdio_dev_oe_n && drv_rises_r == 6'h00 |-> !mdio_dev_o;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("second turnaround bit not zero");
  property p_ta_gap;
    $fell(mdio_dev_oe_n) |-> $past(mdio_host_oe_n, 8);
  endproperty
  a_ta_gap: assert property (p_ta_gap) else $error("first turnaround bit not left undriven");
  property p_drive_len;
    $rose(mdio_dev_oe_n) |-> drv_rises_r == 6'h11;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("device drove wrong number of bits");
  property p_mdc_rate;
    mdc != mdc_q_r |-> stable_r >= 8'(MDC_HALF_CYC - 1);
  endproperty
  a_mdc_rate: assert property (p_mdc_rate) else $error("mdc half period too short");
endmodule

// file: testbench/extended_mdio_register_slave_test.sv
`timescale 1ns/10ps
module extended_mdio_register_slave_test;
  import xms_pkg::*;
  logic        clk_sys, nrst, nrst2, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic        wr1, rd1, wr2, rd2;
  logic [1:0]  strap;
  logic [17:0] s;
  logic [31:0] rdata1, rdata2, cmd_wdata, rsp_rdata, wd1, wd2, cw1, cw2, rsp_seen;
  xms_addr_t   cmd_addr, a1, a2, wa1, wa2;
  int          n_wr1 = 0, n_rd1 = 0, n_wr2 = 0, n_rd2 = 0, n_fail = 0, cmp_count = 0;
  xms_addr_t   wadr [2] = '{10'h3FC, 10'h044};
  logic [31:0] wdat [2] = '{32'h89AB_CDEF, 32'h0123_4567};
  logic [1:0]  bad  [3] = '{2'h0, 2'h2, 2'h3};
  xms_link_if l1 ();
  xms_link_if l2 ();
  xms_host xms_host_i (.clk_sys(clk_sys), .nrst(nrst), .link(l1.host), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready_r(cmd_ready),
    .rsp_valid_r(rsp_valid), .rsp_rdata_r(rsp_rdata));
  xms_dev xms_dev_i (.clk_sys(clk_sys), .nrst(nrst), .link(l1.dev), .mode_strap(strap), .reg_wr_r(wr1),
    .reg_rd_r(rd1), .reg_addr_r(a1), .reg_wdata_r(wd1), .reg_rdata(rdata1));
  // second device faces the bench directly so frames the host never sends can be made
  xms_dev xms_dev_i2 (.clk_sys(clk_sys), .nrst(nrst2), .link(l2.dev), .mode_strap(2'h1), .reg_wr_r(wr2),
    .reg_rd_r(rd2), .reg_addr_r(a2), .reg_wdata_r(wd2), .reg_rdata(rdata2));
  xms_link_asserts xms_link_asserts_i (.clk_sys(clk_sys), .nrst(nrst), .mdc(l1.mdc), .mdio_dev_o(l1.mdio_dev_o),
    .mdio_dev_oe_n(l1.mdio_dev_oe_n), .mdio_host_o(l1.mdio_host_o), .mdio_host_oe_n(l1.mdio_host_oe_n),
    .mdio(l1.mdio));
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // pulses are read on the falling edge, well clear of their launching edge
  always @(negedge clk_sys) begin
    if (wr1 === 1'h1) begin
      n_wr1++;
      wa1 = a1;
      cw1 = wd1;
    end
    if (rd1 === 1'h1) begin
      n_rd1++;
      wa1 = a1;
    end
    if (wr2 === 1'h1) begin
      n_wr2++;
      wa2 = a2;
      cw2 = wd2;
    end
    if (rd2 === 1'h1)
      n_rd2++;
    if (rsp_valid === 1'h1)
      rsp_seen = rsp_rdata;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'h1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 9000)
      chk(32'h0, 32'h1);
  endtask
  task automatic host_xfer(input logic wr, input xms_addr_t a, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    wait_ready();
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    repeat (2) @(negedge clk_sys);
    wait_ready();
    repeat (50) @(negedge clk_sys);
  endtask
  // one frame on the bench link, 160 ns per bit, data set on the falling edge; s keeps the last 18 samples
  task automatic bb_frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, START_CODE, op, phy, rg, 2'h2, d};
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      l2.mdc            <= 1'h0;
      l2.mdio_host_o    <= bits[63-i];
      l2.mdio_host_oe_n <= !(i < 46 || op == OP_WRITE);
      repeat (8) @(posedge clk_sys);
      s = {s[16:0], l2.mdio};
      l2.mdc <= 1'h1;
      repeat (7) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    l2.mdc            <= 1'h0;
    l2.mdio_host_oe_n <= 1'h1;
    repeat (24) @(negedge clk_sys);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    $display("mismatch at %0t: run did not complete", $time);
    finish_test();
  end
  initial begin
    {nrst, nrst2, cmd_valid, cmd_write, cmd_addr, cmd_wdata, rdata1} = '0;
    strap             = 2'h1;
    rdata2            = 32'hA5C3_0F96;
    l2.mdc            = 1'h0;
    l2.mdio_host_o    = 1'h1;
    l2.mdio_host_oe_n = 1'h1;
    repeat (8) @(posedge clk_sys);
    nrst  <= 1'h1;
    nrst2 <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      host_xfer(1'h1, wadr[k], wdat[k]);
      chk(n_wr1, k + 1);
      chk(wa1[9:2], wadr[k][9:2]);
      chk(cw1, wdat[k]);
    end
    $display("test host_write done");
    @(posedge clk_sys);
    rdata1 <= 32'hC3A5_5A3C;
    fork
      host_xfer(1'h0, 10'h2A8, 32'h0);
      begin
        repeat (3000) @(posedge clk_sys);
        rdata1 <= 32'h0F0F_0F0F;
      end
    join
    chk(rsp_seen, 32'hC3A5_5A3C);
    chk(n_rd1, 1);
    chk(wa1[9:2], 8'hAA);
    $display("test host_read done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      strap <= bad[k];
      host_xfer(1'h1, 10'h100, 32'h5555_AAAA);
      chk(n_wr1, 2);
      host_xfer(1'h0, 10'h100, 32'h0);
      chk(rsp_seen, 32'hFFFF_FFFF);
      chk(n_rd1, 1);
    end
    @(posedge clk_sys);
    strap <= 2'h1;
    $display("test straps done");
    bb_frame(OP_WRITE, 5'h0A, 5'h0C, 16'h1111);
    bb_frame(OP_WRITE, 5'h0A, 5'h0D, 16'h2222);
    chk(n_wr2, 0);
    bb_frame(OP_WRITE, 5'h1A, 5'h0D, 16'hBEEF);
    chk(n_wr2, 0);
    bb_frame(OP_WRITE, 5'h1A, 5'h0C, 16'h7E01);
    chk(n_wr2, 1);
    chk(wa2[9:2], 8'hA6);
    chk(cw2, 32'hBEEF_7E01);
    bb_frame(OP_READ, 5'h1A, 5'h0C, 16'h0);
    chk(s, {2'h2, rdata2[15:0]});
    bb_frame(OP_READ, 5'h1A, 5'h0D, 16'h0);
    chk(s, {2'h2, rdata2[31:16]});
    chk(n_rd2, 1);
    bb_frame(OP_WRITE, 5'h1A, 5'h0E, 16'h3333);
    bb_frame(OP_WRITE, 5'h1A, 5'h0E, 16'h4444);
    chk(n_wr2, 1);
    @(posedge clk_sys);
    nrst2 <= 1'h0;
    repeat (8) @(posedge clk_sys);
    nrst2 <= 1'h1;
    bb_frame(OP_READ, 5'h1A, 5'h0E, 16'h0);
    bb_frame(OP_READ, 5'h1A, 5'h0E, 16'h0);
    chk(n_rd2, 1);
    $display("test direct_link done");
    finish_test();
  end
endmodule
